// *** dmsr_pkg.sv ***
// Register numbers, field positions and widths of the drive monitor register bank
package dmsr_pkg;

   // Data and address widths, terminal and output counts
   localparam int unsigned DMSR_DATA_W = 16;
   localparam int unsigned DMSR_ADDR_W = 16;
   localparam int unsigned DMSR_TERM_N = 12;
   localparam int unsigned DMSR_OUTS_N = 5;

   // Register numbers
   localparam logic [15:0] DMSR_REG_TERMINAL_INPUT_SNAPSHOT = 16'h002B;
   localparam logic [15:0] DMSR_REG_DRIVE_STATE_WORD        = 16'h002C;
   localparam logic [15:0] DMSR_REG_OUTPUT_CONTACT_STATE    = 16'h002D;
   localparam logic [15:0] DMSR_REG_DC_BUS_VOLTAGE_MONITOR  = 16'h0031;
   localparam logic [15:0] DMSR_REG_TORQUE_MONITOR_VALUE    = 16'h0032;
   localparam logic [15:0] DMSR_REG_OUTPUT_POWER_MONITOR    = 16'h0033;
   localparam logic [15:0] DMSR_REG_PID_FEEDBACK_VALUE      = 16'h0038;
   localparam logic [15:0] DMSR_REG_SIGNED_PID_QUANTITY_A   = 16'h0039;
   localparam logic [15:0] DMSR_REG_SIGNED_PID_QUANTITY_B   = 16'h003A;
   localparam logic [15:0] DMSR_REG_CPU_FIRMWARE_NUMBER     = 16'h003B;
   localparam logic [15:0] DMSR_REG_FLASH_FIRMWARE_NUMBER   = 16'h003C;
   localparam logic [15:0] DMSR_REG_LINK_ERROR_FLAGS        = 16'h003D;
   localparam logic [15:0] DMSR_REG_POWER_RATING_SETTING    = 16'h003E;
   localparam logic [15:0] DMSR_REG_CONTROL_METHOD_CODE     = 16'h003F;

   // Drive state word bit positions
   localparam int unsigned DMSR_ST_RUNNING      = 0;
   localparam int unsigned DMSR_ST_ZERO_SPEED   = 1;
   localparam int unsigned DMSR_ST_FREQ_MATCH   = 2;
   localparam int unsigned DMSR_ST_USER_MATCH   = 3;
   localparam int unsigned DMSR_ST_FREQ_DET1    = 4;
   localparam int unsigned DMSR_ST_FREQ_DET2    = 5;
   localparam int unsigned DMSR_ST_STARTUP_DONE = 6;
   localparam int unsigned DMSR_ST_LOW_VOLTAGE  = 7;
   localparam int unsigned DMSR_ST_BLOCKED      = 8;
   localparam int unsigned DMSR_ST_FREF_NOTLINK = 9;
   localparam int unsigned DMSR_ST_RUN_NOTLINK  = 10;
   localparam int unsigned DMSR_ST_OVERTORQUE   = 11;
   localparam int unsigned DMSR_ST_FREF_LOST    = 12;
   localparam int unsigned DMSR_ST_RETRYING     = 13;
   localparam int unsigned DMSR_ST_ANY_FAULT    = 14;
   localparam int unsigned DMSR_ST_LINK_TIMEOUT = 15;

   // Link error flag bit positions
   localparam int unsigned DMSR_ERR_CRC     = 0;
   localparam int unsigned DMSR_ERR_LENGTH  = 1;
   localparam int unsigned DMSR_ERR_PARITY  = 3;
   localparam int unsigned DMSR_ERR_OVERRUN = 4;
   localparam int unsigned DMSR_ERR_FRAMING = 5;
   localparam int unsigned DMSR_ERR_TIMEOUT = 6;

   // Implemented link error flags, other bits read zero
   localparam logic [15:0] DMSR_ERR_IMPL_MASK = 16'h007B;

   // Reset values
   localparam logic [15:0] DMSR_WORD_RESET = 16'h0000;

endpackage : dmsr_pkg

// *** dmsr_sync.sv ***
// Two flip-flop synchroniser for asynchronous level inputs
`timescale 1ns/1ns
module dmsr_sync #(
   parameter int unsigned WIDTH = 1
) (
   // Clock and reset
   input  wire logic             mclk,
   input  wire logic             rstn,
   // Asynchronous input and synchronised output
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] stage_one;
   logic [WIDTH-1:0] next_stage_one;
   logic [WIDTH-1:0] next_sync_out;

   // Next values of both stages
   always_comb begin
      next_stage_one = async_in;
      next_sync_out  = stage_one;
   end

   // Stage registers, first stage read only by the second
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         stage_one <= '0;
         sync_out  <= '0;
      end else begin
         stage_one <= next_stage_one;
         sync_out  <= next_sync_out;
      end
   end

endmodule : dmsr_sync

// *** dmsr_monitor_bank.sv ***
// Read-only monitor register bank of the drive serial slave interface
//
// Operation
// R1: Terminal inputs 1 to 12 in bits 0-B
// R2: Bits 0-3: running, zero speed, matches
// R3: Bits 4-5 frequency detection, bit 6 startup
// R4: Bit 7 low voltage, bit 8 blocked
// R5: Bit 9 zero when reference from link
// R6: Bit A zero when run from link
// R7: Bit B overtorque, bit C reference lost
// R8: Bit D set while retrying after fault
// R9: Bit E any fault, including link timeout
// R10: Bit F set on link timeout
// R11: Relays bits 0-2, photocouplers bits 3-4
// R12: Link error flags latch until fault reset
// R13: Fault reset clears flags even while running
// R14: Bus voltage, torque, power at 0031H onward
// R15: PID feedback unsigned, ten counts per percent
// R16: 0039H and 003AH signed, ten per percent
// R17: Writes never alter monitor registers
// R18: Unused bits and numbers read zero
`timescale 1ns/1ns
module dmsr_monitor_bank
   import dmsr_pkg::*;
(
   // Clock and reset
   input  wire logic        mclk,
   input  wire logic        rstn,
   // Register access from the serial slave
   input  wire logic        reg_rd_en,
   input  wire logic        reg_wr_en,
   input  wire logic [15:0] reg_addr,
   input  wire logic [15:0] reg_wdata,
   output logic      [15:0] reg_rdata,
   output logic             reg_rd_valid,
   output logic             reg_wr_refused,
   // Control terminal pins, asynchronous
   input  wire logic [11:0] control_inputs,
   // Output contact states, drive logic
   input  wire logic        relay_output_one,
   input  wire logic        relay_output_two,
   input  wire logic        relay_output_three,
   input  wire logic        photocoupler_output_three,
   input  wire logic        photocoupler_output_four,
   // Drive state levels, drive logic
   input  wire logic        drive_running,
   input  wire logic        zero_speed,
   input  wire logic        freq_matched,
   input  wire logic        user_speed_matched,
   input  wire logic        freq_detect_one,
   input  wire logic        freq_detect_two,
   input  wire logic        startup_done,
   input  wire logic        low_voltage,
   input  wire logic        output_blocked,
   input  wire logic        freq_ref_from_link,
   input  wire logic        run_cmd_from_link,
   input  wire logic        overtorque,
   input  wire logic        freq_ref_lost,
   input  wire logic        fault_retrying,
   input  wire logic        fault_present,
   input  wire logic        link_timed_out,
   // Monitor quantities, drive logic
   input  wire logic [15:0] dc_bus_voltage,
   input  wire logic [15:0] torque_value,
   input  wire logic [15:0] output_power,
   input  wire logic [15:0] pid_feedback,
   input  wire logic [15:0] pid_signed_a,
   input  wire logic [15:0] pid_signed_b,
   input  wire logic [15:0] cpu_firmware,
   input  wire logic [15:0] flash_firmware,
   input  wire logic [15:0] power_rating,
   input  wire logic [15:0] control_method,
   // Link error events, one-cycle pulses
   input  wire logic        evt_crc_error,
   input  wire logic        evt_length_error,
   input  wire logic        evt_parity_error,
   input  wire logic        evt_overrun_error,
   input  wire logic        evt_framing_error,
   input  wire logic        evt_timeout_error,
   // Fault reset, one-cycle pulse
   input  wire logic        fault_reset
);

   // Synchronised pins and held status words
   logic [11:0] terminals_sync;
   logic [15:0] terminal_input_snapshot;
   logic [15:0] drive_state_word;
   logic [15:0] output_contact_state;
   logic [15:0] link_error_flags;
   // Next values of the held words
   logic [15:0] next_terminal_input_snapshot;
   logic [15:0] next_drive_state_word;
   logic [15:0] next_output_contact_state;
   logic [15:0] next_link_error_flags;
   // Error events at their flag positions
   logic [15:0] error_events;
   // Next read answer
   logic [15:0] next_reg_rdata;
   logic        next_reg_rd_valid;
   logic        next_reg_wr_refused;

   // Terminal pins cross into the clock domain
   dmsr_sync #(
      .WIDTH    (DMSR_TERM_N)
   ) u_term_sync (
      .mclk     (mclk),
      .rstn     (rstn),
      .async_in (control_inputs),
      .sync_out (terminals_sync)
   );

   // Terminal snapshot, upper bits zero
   always_comb begin
      next_terminal_input_snapshot = DMSR_WORD_RESET;
      next_terminal_input_snapshot[DMSR_TERM_N-1:0] = terminals_sync; // see R1
   end

   // Drive state word assembly
   always_comb begin
      next_drive_state_word = DMSR_WORD_RESET;
      next_drive_state_word[DMSR_ST_RUNNING]      = drive_running;        // see R2
      next_drive_state_word[DMSR_ST_ZERO_SPEED]   = zero_speed;           // see R2
      next_drive_state_word[DMSR_ST_FREQ_MATCH]   = freq_matched;         // see R2
      next_drive_state_word[DMSR_ST_USER_MATCH]   = user_speed_matched;   // see R2
      next_drive_state_word[DMSR_ST_FREQ_DET1]    = freq_detect_one;      // see R3
      next_drive_state_word[DMSR_ST_FREQ_DET2]    = freq_detect_two;      // see R3
      next_drive_state_word[DMSR_ST_STARTUP_DONE] = startup_done;         // see R3
      next_drive_state_word[DMSR_ST_LOW_VOLTAGE]  = low_voltage;          // see R4
      next_drive_state_word[DMSR_ST_BLOCKED]      = output_blocked;       // see R4
      next_drive_state_word[DMSR_ST_FREF_NOTLINK] = ~freq_ref_from_link;  // see R5
      next_drive_state_word[DMSR_ST_RUN_NOTLINK]  = ~run_cmd_from_link;   // see R6
      next_drive_state_word[DMSR_ST_OVERTORQUE]   = overtorque;           // see R7
      next_drive_state_word[DMSR_ST_FREF_LOST]    = freq_ref_lost;        // see R7
      next_drive_state_word[DMSR_ST_RETRYING]     = fault_retrying;       // see R8
      // Summary fault includes the link timeout
      next_drive_state_word[DMSR_ST_ANY_FAULT]    = fault_present | link_timed_out; // see R9
      next_drive_state_word[DMSR_ST_LINK_TIMEOUT] = link_timed_out;       // see R10
   end

   // Contact and photocoupler states, bits 5 up zero
   always_comb begin
      next_output_contact_state    = DMSR_WORD_RESET;
      next_output_contact_state[0] = relay_output_one;          // see R11
      next_output_contact_state[1] = relay_output_two;          // see R11
      next_output_contact_state[2] = relay_output_three;        // see R11
      next_output_contact_state[3] = photocoupler_output_three; // see R11
      next_output_contact_state[4] = photocoupler_output_four;  // see R11
   end

   // Error events gathered at their flag positions
   always_comb begin
      error_events                   = DMSR_WORD_RESET;
      error_events[DMSR_ERR_CRC]     = evt_crc_error;
      error_events[DMSR_ERR_LENGTH]  = evt_length_error;
      error_events[DMSR_ERR_PARITY]  = evt_parity_error;
      error_events[DMSR_ERR_OVERRUN] = evt_overrun_error;
      error_events[DMSR_ERR_FRAMING] = evt_framing_error;
      error_events[DMSR_ERR_TIMEOUT] = evt_timeout_error;
   end

   // Sticky flag per bit; a new event beats a fault reset
   generate
      for (genvar b = 0; b < DMSR_DATA_W; b++) begin : g_err_flag
         if (DMSR_ERR_IMPL_MASK[b]) begin : g_impl
            always_comb begin
               if (error_events[b]) begin
                  next_link_error_flags[b] = 1'b1;   // see R12
               end else if (fault_reset) begin
                  next_link_error_flags[b] = 1'b0;   // see R13
               end else begin
                  next_link_error_flags[b] = link_error_flags[b]; // see R12
               end
            end
         end else begin : g_unused
            // No event source, bit stays zero
            always_comb begin
               next_link_error_flags[b] = 1'b0;      // see R18
            end
         end
      end
   endgenerate

   // Read multiplexer over the monitor range
   always_comb begin
      next_reg_rdata      = reg_rdata;
      next_reg_rd_valid   = 1'b0;
      next_reg_wr_refused = 1'b0;
      if (reg_rd_en) begin
         next_reg_rd_valid = 1'b1;
         case (reg_addr)
            DMSR_REG_TERMINAL_INPUT_SNAPSHOT: begin
               // Terminal pins, upper four bits zero
               next_reg_rdata = terminal_input_snapshot;
            end
            DMSR_REG_DRIVE_STATE_WORD: begin
               // Drive state word, registered once
               next_reg_rdata = drive_state_word;
            end
            DMSR_REG_OUTPUT_CONTACT_STATE: begin
               // Contact and photocoupler states
               next_reg_rdata = output_contact_state;
            end
            DMSR_REG_DC_BUS_VOLTAGE_MONITOR: begin
               // Bus voltage, sampled at the read edge
               next_reg_rdata = dc_bus_voltage;   // see R14
            end
            DMSR_REG_TORQUE_MONITOR_VALUE: begin
               // Torque monitor word
               next_reg_rdata = torque_value;     // see R14
            end
            DMSR_REG_OUTPUT_POWER_MONITOR: begin
               // Output power word
               next_reg_rdata = output_power;     // see R14
            end
            DMSR_REG_PID_FEEDBACK_VALUE: begin
               // Unsigned, ten counts per percent of max frequency
               next_reg_rdata = pid_feedback;     // see R15
            end
            DMSR_REG_SIGNED_PID_QUANTITY_A: begin
               // Two's complement, ten counts per percent
               next_reg_rdata = pid_signed_a;     // see R16
            end
            DMSR_REG_SIGNED_PID_QUANTITY_B: begin
               // Second signed quantity, same scaling
               next_reg_rdata = pid_signed_b;     // see R16
            end
            DMSR_REG_CPU_FIRMWARE_NUMBER: begin
               // Processor firmware number, raw
               next_reg_rdata = cpu_firmware;
            end
            DMSR_REG_FLASH_FIRMWARE_NUMBER: begin
               // Flash firmware number, raw
               next_reg_rdata = flash_firmware;
            end
            DMSR_REG_LINK_ERROR_FLAGS: begin
               // Sticky link error flags
               next_reg_rdata = link_error_flags;
            end
            DMSR_REG_POWER_RATING_SETTING: begin
               // Power rating, raw
               next_reg_rdata = power_rating;
            end
            DMSR_REG_CONTROL_METHOD_CODE: begin
               // Control method code, raw
               next_reg_rdata = control_method;
            end
            default: begin
               // Spare numbers read zero
               next_reg_rdata = DMSR_WORD_RESET;  // see R18
            end
         endcase
      end else if (reg_wr_en) begin
         // Writes are flagged and otherwise dropped
         next_reg_wr_refused = 1'b1;              // see R17
      end
   end

   // Snapshot and flag registers; no write path reaches them
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         terminal_input_snapshot <= DMSR_WORD_RESET;
         drive_state_word        <= DMSR_WORD_RESET;
         output_contact_state    <= DMSR_WORD_RESET;
         link_error_flags        <= DMSR_WORD_RESET;
      end else begin
         terminal_input_snapshot <= next_terminal_input_snapshot;
         drive_state_word        <= next_drive_state_word;
         output_contact_state    <= next_output_contact_state;
         link_error_flags        <= next_link_error_flags;
      end
   end

   // Read answer registers
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         reg_rdata      <= DMSR_WORD_RESET;
         reg_rd_valid   <= 1'b0;
         reg_wr_refused <= 1'b0;
      end else begin
         reg_rdata      <= next_reg_rdata;
         reg_rd_valid   <= next_reg_rd_valid;
         reg_wr_refused <= next_reg_wr_refused;
      end
   end

endmodule : dmsr_monitor_bank

// *** dmsr_monitor_bank_asserts.sv ***
// Concurrent checks on the ports of the drive monitor register bank
`timescale 1ns/1ns
module dmsr_monitor_bank_asserts (
   // Clock and reset
   input  wire logic        mclk,
   input  wire logic        rstn,
   // Register access
   input  wire logic        reg_rd_en,
   input  wire logic        reg_wr_en,
   input  wire logic [15:0] reg_addr,
   input  wire logic [15:0] reg_rdata,
   input  wire logic        reg_rd_valid,
   input  wire logic        reg_wr_refused,
   // Drive side levels and pulses
   input  wire logic        freq_ref_from_link,
   input  wire logic        fault_present,
   input  wire logic        link_timed_out,
   input  wire logic [15:0] dc_bus_voltage,
   input  wire logic        evt_crc_error,
   input  wire logic        fault_reset
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rstn);

   // Access handshake
   AST_READ_ANSWER: assert property (reg_rd_en |=> reg_rd_valid && !reg_wr_refused)
      else $error("read not answered");
   AST_WRITE_REFUSED: assert property ((reg_wr_en && !reg_rd_en) |=> reg_wr_refused && !reg_rd_valid)
      else $error("write not refused");
   // Field contents
   AST_TERM_UNUSED: assert property ((reg_rd_en && reg_addr == 16'h002B) |=> reg_rdata[15:12] == 4'h0)
      else $error("terminal spare bits set");
   AST_FREF_SOURCE: assert property ((reg_rd_en && reg_addr == 16'h002C) |=> reg_rdata[9] == !$past(freq_ref_from_link, 2))
      else $error("reference source bit wrong");
   AST_ANY_FAULT: assert property ((reg_rd_en && reg_addr == 16'h002C)
      |=> reg_rdata[14] == ($past(fault_present, 2) | $past(link_timed_out, 2)))
      else $error("fault summary bit wrong");
   AST_LINK_TIMEOUT: assert property ((reg_rd_en && reg_addr == 16'h002C) |=> reg_rdata[15] == $past(link_timed_out, 2))
      else $error("timeout bit wrong");
   AST_OUTS_UNUSED: assert property ((reg_rd_en && reg_addr == 16'h002D) |=> reg_rdata[15:5] == 11'h000)
      else $error("output spare bits set");
   AST_BUS_VOLTAGE: assert property ((reg_rd_en && reg_addr == 16'h0031) |=> reg_rdata == $past(dc_bus_voltage))
      else $error("bus voltage word wrong");
   // Sticky flags and unmapped words
   AST_CRC_STICKY: assert property (evt_crc_error ##1 (reg_rd_en && reg_addr == 16'h003D) |=> reg_rdata[0])
      else $error("crc flag not latched");
   AST_RESET_CLEARS: assert property ((fault_reset && !evt_crc_error) ##1 (reg_rd_en && reg_addr == 16'h003D)
      |=> !reg_rdata[0])
      else $error("crc flag not cleared");
   AST_UNMAPPED: assert property ((reg_rd_en && reg_addr == 16'h0030) |=> reg_rdata == 16'h0000)
      else $error("unmapped word not zero");
endmodule : dmsr_monitor_bank_asserts

bind dmsr_monitor_bank dmsr_monitor_bank_asserts dmsr_monitor_bank_asserts_i (
   .mclk(mclk), .rstn(rstn), .reg_rd_en(reg_rd_en), .reg_wr_en(reg_wr_en), .reg_addr(reg_addr),
   .reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid), .reg_wr_refused(reg_wr_refused),
   .freq_ref_from_link(freq_ref_from_link), .fault_present(fault_present),
   .link_timed_out(link_timed_out), .dc_bus_voltage(dc_bus_voltage),
   .evt_crc_error(evt_crc_error), .fault_reset(fault_reset)
);

// *** dmsr_master_model.sv ***
// Serial master model issuing register reads and writes
`timescale 1ns/1ns
module dmsr_master_model (
   // Clock
   input  wire logic        mclk,
   // Requests
   output logic             reg_rd_en,
   output logic             reg_wr_en,
   output logic      [15:0] reg_addr,
   output logic      [15:0] reg_wdata,
   // Answers
   input  wire logic [15:0] reg_rdata,
   input  wire logic        reg_rd_valid,
   input  wire logic        reg_wr_refused
);
   // Idle request lines
   initial begin
      reg_rd_en = 1'b0;
      reg_wr_en = 1'b0;
      reg_addr  = 16'h0000;
      reg_wdata = 16'h0000;
   end
   // Read, answer sampled one edge after the taking edge; address scrambled after
   task automatic read_word(input logic [15:0] a, output logic [15:0] d, output logic v);
      reg_rd_en <= 1'b1;
      reg_addr  <= a;
      @(posedge mclk);
      reg_rd_en <= 1'b0;
      reg_addr  <= ~a;
      @(posedge mclk);
      d = reg_rdata;
      v = reg_rd_valid;
   endtask : read_word
   // Write attempt, refusal sampled one edge later
   task automatic write_word(input logic [15:0] a, input logic [15:0] w, output logic r);
      reg_wr_en <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= w;
      @(posedge mclk);
      reg_wr_en <= 1'b0;
      reg_addr  <= ~a;
      reg_wdata <= ~w;
      @(posedge mclk);
      r = reg_wr_refused;
   endtask : write_word
   // Read and write raised together; the read must win
   task automatic read_over_write(input logic [15:0] a, output logic [15:0] d,
                                  output logic v, output logic r);
      reg_rd_en <= 1'b1;
      reg_wr_en <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= 16'hFFFF;
      @(posedge mclk);
      reg_rd_en <= 1'b0;
      reg_wr_en <= 1'b0;
      reg_addr  <= ~a;
      reg_wdata <= 16'h0000;
      @(posedge mclk);
      d = reg_rdata;
      v = reg_rd_valid;
      r = reg_wr_refused;
   endtask : read_over_write
endmodule : dmsr_master_model

// *** dmsr_monitor_bank_tb.sv ***
// Self-checking testbench of the drive monitor register bank
`timescale 1ns/1ns
module dmsr_monitor_bank_tb
   import dmsr_pkg::*;
;
   localparam logic [15:0] MON_ADDR [10] = '{16'h0031, 16'h0032, 16'h0033, 16'h0038, 16'h0039,
                                              16'h003A, 16'h003B, 16'h003C, 16'h003E, 16'h003F};
   localparam logic [15:0] MON_VAL [10] = '{16'h0155, 16'hFF38, 16'h0A12, 16'h03E8, 16'hFC18,
                                             16'h03E8, 16'h0102, 16'h0203, 16'h0075, 16'h0002};
   localparam logic [15:0] SPARE [8] = '{16'h0029, 16'h002A, 16'h002E, 16'h002F, 16'h0030,
                                          16'h0034, 16'h0037, 16'h0040};
   logic        mclk = 1'b0;
   logic        rstn, rd_en, wr_en, valid, refused, fault_rst;
   logic [15:0] addr, wdata, rdata, st_in, exp;
   logic [15:0] mon [10];
   logic [4:0]  outs;
   logic [11:0] ctl;
   logic [6:0]  evt_v;
   logic [15:0] both_d;
   logic        both_v, both_r;
   int          fails = 0;
   int          cmp_count = 0;
   int          cycles = 0;

   // Clock
   always #20 mclk = ~mclk;

   dmsr_master_model dmsr_master_model_i (.mclk(mclk), .reg_rd_en(rd_en), .reg_wr_en(wr_en),
      .reg_addr(addr), .reg_wdata(wdata), .reg_rdata(rdata), .reg_rd_valid(valid),
      .reg_wr_refused(refused));
   dmsr_monitor_bank dmsr_monitor_bank_i (.mclk(mclk), .rstn(rstn), .reg_rd_en(rd_en),
      .reg_wr_en(wr_en), .reg_addr(addr), .reg_wdata(wdata), .reg_rdata(rdata),
      .reg_rd_valid(valid), .reg_wr_refused(refused), .control_inputs(ctl),
      .relay_output_one(outs[0]), .relay_output_two(outs[1]), .relay_output_three(outs[2]),
      .photocoupler_output_three(outs[3]), .photocoupler_output_four(outs[4]),
      .drive_running(st_in[0]), .zero_speed(st_in[1]), .freq_matched(st_in[2]),
      .user_speed_matched(st_in[3]), .freq_detect_one(st_in[4]), .freq_detect_two(st_in[5]),
      .startup_done(st_in[6]), .low_voltage(st_in[7]), .output_blocked(st_in[8]),
      .freq_ref_from_link(st_in[9]), .run_cmd_from_link(st_in[10]), .overtorque(st_in[11]),
      .freq_ref_lost(st_in[12]), .fault_retrying(st_in[13]), .fault_present(st_in[14]),
      .link_timed_out(st_in[15]), .dc_bus_voltage(mon[0]), .torque_value(mon[1]),
      .output_power(mon[2]), .pid_feedback(mon[3]), .pid_signed_a(mon[4]),
      .pid_signed_b(mon[5]), .cpu_firmware(mon[6]), .flash_firmware(mon[7]),
      .power_rating(mon[8]), .control_method(mon[9]), .evt_crc_error(evt_v[0]),
      .evt_length_error(evt_v[1]), .evt_parity_error(evt_v[3]), .evt_overrun_error(evt_v[4]),
      .evt_framing_error(evt_v[5]), .evt_timeout_error(evt_v[6]), .fault_reset(fault_rst));

   // Comparison and reporting
   task automatic check(input logic [15:0] seen, input logic [15:0] want);
      cmp_count++;
      if (seen !== want) begin
         fails++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
      end
   endtask : check
   task automatic rd_chk(input logic [15:0] a, input logic [15:0] want);
      logic [15:0] d;
      logic        v;
      dmsr_master_model_i.read_word(a, d, v);
      check({15'h0000, v}, 16'h0001);
      check(d, want);
   endtask : rd_chk
   task automatic wr_chk(input logic [15:0] a);
      logic r;
      dmsr_master_model_i.write_word(a, 16'hFFFF, r);
      check({15'h0000, r}, 16'h0001);
   endtask : wr_chk
   task automatic pulse(input logic [6:0] e, input logic r);
      @(posedge mclk);
      evt_v     <= e;
      fault_rst <= r;
      @(posedge mclk);
      evt_v     <= 7'h00;
      fault_rst <= 1'b0;
   endtask : pulse
   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : finish_test

   // Hang guard
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 5000) begin
         fails++;
         finish_test();
      end
   end

   // Main sequence
   initial begin
      rstn = 1'b0;
      st_in = 16'h0000;
      outs = 5'h00;
      ctl = 12'h000;
      evt_v = 7'h00;
      fault_rst = 1'b0;
      mon = '{default: 16'h0000};
      repeat (12) @(posedge mclk);
      rstn <= 1'b1;
      repeat (2) @(posedge mclk);
      rd_chk(16'h003D, DMSR_WORD_RESET);
      for (int i = 0; i < 17; i++) begin
         exp = (i == 16) ? 16'hFFFF : 16'h0001 << i;
         st_in <= exp;
         exp = exp ^ 16'h0600;
         exp[14] = exp[14] | exp[15];
         repeat (3) @(posedge mclk);
         rd_chk(16'h002C, exp);
      end
      for (int i = 0; i < 6; i++) begin
         outs <= (i == 5) ? 5'h1F : 5'h01 << i;
         repeat (3) @(posedge mclk);
         rd_chk(16'h002D, (i == 5) ? 16'h001F : 16'h0001 << i);
      end
      for (int i = 0; i < 13; i++) begin
         ctl <= (i == 12) ? 12'hFFF : 12'h001 << i;
         repeat (5) @(posedge mclk);
         rd_chk(16'h002B, (i == 12) ? 16'h0FFF : 16'h0001 << i);
      end
      for (int i = 0; i < 10; i++) mon[i] <= MON_VAL[i];
      for (int i = 0; i < 10; i++) rd_chk(MON_ADDR[i], MON_VAL[i]);
      for (int i = 0; i < 8; i++) rd_chk(SPARE[i], 16'h0000);
      st_in <= 16'h0001;
      repeat (3) @(posedge mclk);
      wr_chk(16'h002C);
      rd_chk(16'h002C, 16'h0601);
      exp = 16'h0000;
      for (int i = 0; i < 7; i++) begin
         if (i != 2) begin
            pulse(7'h01 << i, 1'b0);
            exp[i] = 1'b1;
            rd_chk(16'h003D, exp);
         end
      end
      wr_chk(16'h003D);
      rd_chk(16'h003D, DMSR_ERR_IMPL_MASK);
      dmsr_master_model_i.read_over_write(16'h003D, both_d, both_v, both_r);
      check(both_d, DMSR_ERR_IMPL_MASK);
      check({15'h0000, both_v}, 16'h0001);
      check({15'h0000, both_r}, 16'h0000);
      pulse(7'h00, 1'b1);
      rd_chk(16'h003D, 16'h0000);
      pulse(7'h01, 1'b1);
      rd_chk(16'h003D, 16'h0001);
      finish_test();
   end
endmodule : dmsr_monitor_bank_tb
